// ### shared/tms_pkg.sv
/*
  Shared constants and types of the TAP master sequencer: register map, field
  layouts, reset values and the TAP state encoding.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package tms_pkg;

  // Byte addresses, one aligned word each
  localparam logic [7:0] TMS_ADDR_CMD    = 8'h00;
  localparam logic [7:0] TMS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] TMS_ADDR_LEN    = 8'h08;
  localparam logic [7:0] TMS_ADDR_OUTBUF = 8'h0C;
  localparam logic [7:0] TMS_ADDR_DISC   = 8'h10;
  localparam logic [7:0] TMS_ADDR_CFG    = 8'h14;

  // Status field positions
  localparam int TMS_STAT_FULL_BIT = 6;
  localparam int TMS_STAT_BUSY_BIT = 5;

  // Values after reset
  localparam logic [7:0]  TMS_CFG_RESET  = 8'h00;
  localparam logic [7:0]  TMS_DISC_RESET = 8'h03;
  localparam logic [15:0] TMS_LEN_RESET  = 16'h0000;

  // Reset divider of the test clock
  localparam int TMS_TCK_DIV_RESET = 16;

  // Outgoing buffer shape
  localparam int TMS_BUF_WIDTH = 8;
  localparam int TMS_BUF_DEPTH = 4;

  // Stable goal codes of the command register
  localparam logic [2:0] TMS_GOAL_RESET    = 3'h0;
  localparam logic [2:0] TMS_GOAL_IDLE     = 3'h1;
  localparam logic [2:0] TMS_GOAL_SHIFT_DR = 3'h2;
  localparam logic [2:0] TMS_GOAL_PAUSE_DR = 3'h3;
  localparam logic [2:0] TMS_GOAL_SHIFT_IR = 3'h4;
  localparam logic [2:0] TMS_GOAL_PAUSE_IR = 3'h5;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tms_tap_t;

  typedef enum logic [1:0] {
    MODE_BUFFER, MODE_IN_ONLY, MODE_RECIRC, MODE_MOVE
  } tms_mode_t;

  typedef struct packed {
    logic      soft_reset_bit;
    logic      rsvd;
    logic      ir_path;
    tms_mode_t mode;
    logic [2:0] goal;
  } tms_cmd_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       trst_assert;
    logic       loopback;
    logic       discrete;
  } tms_cfg_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       tms_level;
    logic       tdo_level;
  } tms_disc_t;

endpackage

// ### core/tms_out_fifo.sv
/*
  Outgoing scan byte FIFO with valid/ready on both sides and a clear input.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module tms_out_fifo
  import tms_pkg::*;
#(
  parameter int WIDTH = TMS_BUF_WIDTH,
  parameter int DEPTH = TMS_BUF_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             clear_i,
  input  wire logic             push_valid_i,
  output logic                  push_ready_o,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic                  pop_valid_o,
  input  wire logic             pop_ready_i,
  output logic [WIDTH-1:0]      pop_data_o,
  output logic                  full_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
    $error("tms_out_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign full_o       = (cnt_q == (AW+1)'(DEPTH));
  assign push_ready_o = ~full_o;
  assign pop_valid_o  = (cnt_q != '0);
  assign pop_data_o   = mem_q[rd_q];
  assign push         = push_valid_i & push_ready_o;
  assign pop          = pop_ready_i & pop_valid_o;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clear_i)) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule

// ### core/tms_tap_master.sv
/*
  TAP master sequencer: TMS generation toward stable states, target state
  record, test clock divider and serialisation of the outgoing scan buffer.
  Assumes a classic Wishbone master, one clock and target devices on the pins.
*/
// Chosen here: register access over Wishbone and the address map.
// Contract
// - Shift-DR to reset or idle sequences
// - Shift-DR to pause sequences
// - Shift-IR to reset, idle, Pause-IR sequences
// - Shift-IR to Pause-DR sequence, hold low
// - One state per TCK rise from TMS
// - Sixteen states, six stable, ten transient
// - Reset state entered on every reset kind
// - Select states left after one cycle
// - Exit to shift without recapture; pause holds
// - Four-byte FIFO, LSB first, right justified
// - Command start clears the outgoing buffer
// - Full flag bit 6, writes stalled while full
// - Input-only drives high; recirculate returns input
// - Discrete mode drives output from register
// - Loopback feeds buffer inward, pins held high
// - Any reset empties buffer, not full
// - Reset drives pins high, TCK divided sixteen
`timescale 1ns/1ps
module tms_tap_master
  import tms_pkg::*;
#(
  parameter int TCK_DIV = TMS_TCK_DIV_RESET
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tdi_i,
  output logic             tck_o,
  output logic             tms_o,
  output logic             tdo_o,
  output logic             trst_n_o,
  output logic             loop_bit_o,
  output logic             loop_valid_o
);
  localparam int HALF = TCK_DIV / 2;
  localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

  if (TCK_DIV < 4 || (TCK_DIV % 2) != 0) begin : g_check
    $error("tms_tap_master: TCK_DIV must be even and at least 4");
  end

  // Next state of the TAP controller
  function automatic tms_tap_t tap_next(tms_tap_t s, logic t);
    tms_tap_t n;
    n = s;
    unique case (s)
      TAP_RESET:    n = t ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:     n = t ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   n = t ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   n = t ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = t ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = t ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = t ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = t ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   n = t ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   n = t ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR:   n = t ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = t ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = t ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = t ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = t ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   n = t ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return n;
  endfunction

  // TMS level that moves one step along the shortest path to a stable goal
  function automatic logic tms_toward(tms_tap_t s, tms_tap_t g);
    logic t;
    logic dr_goal;
    logic ir_goal;
    dr_goal = (g == TAP_SHIFT_DR) || (g == TAP_PAUSE_DR);
    ir_goal = (g == TAP_SHIFT_IR) || (g == TAP_PAUSE_IR);
    t = 1'b1;
    unique case (s)
      TAP_RESET:    t = (g == TAP_RESET);
      TAP_IDLE:     t = (g != TAP_IDLE);
      TAP_SEL_DR:   t = ~dr_goal;
      TAP_SEL_IR:   t = ~ir_goal;
      TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT2_DR:
        t = (g != TAP_SHIFT_DR);
      TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT2_IR:
        t = (g != TAP_SHIFT_IR);
      TAP_EXIT1_DR: t = ~dr_goal;
      TAP_EXIT1_IR: t = ~ir_goal;
      TAP_PAUSE_DR: t = (g != TAP_PAUSE_DR);
      TAP_PAUSE_IR: t = (g != TAP_PAUSE_IR);
      TAP_UPD_DR, TAP_UPD_IR:
        t = (g != TAP_IDLE);
    endcase
    return t;
  endfunction

  function automatic tms_tap_t goal_state(logic [2:0] c);
    tms_tap_t g;
    unique case (c)
      TMS_GOAL_RESET:    g = TAP_RESET;
      TMS_GOAL_SHIFT_DR: g = TAP_SHIFT_DR;
      TMS_GOAL_PAUSE_DR: g = TAP_PAUSE_DR;
      TMS_GOAL_SHIFT_IR: g = TAP_SHIFT_IR;
      TMS_GOAL_PAUSE_IR: g = TAP_PAUSE_IR;
      default:           g = TAP_IDLE;
    endcase
    return g;
  endfunction

  logic            soft_rst_q;
  logic            rst_all;
  logic            ack_q;
  logic [31:0]     rdat_q;
  logic [31:0]     rdat;
  tms_cfg_t        cfg_q;
  tms_disc_t       disc_q;
  logic [15:0]     len_q;
  tms_cmd_t        cmd;
  logic            req;
  logic            wr_fire;
  logic            hit_cmd;
  logic            hit_out;
  logic            start;
  logic            busy_q;
  logic            scan_q;
  tms_mode_t       mode_q;
  tms_tap_t        goal_q;
  tms_tap_t        target_q;
  tms_tap_t        tap_q;
  logic [15:0]     rem_q;
  logic [2:0]      bit_q;
  logic            tms_q;
  logic            tdo_q;
  logic            tck_q;
  logic [CW-1:0]   cnt_q;
  logic            in_shift;
  logic            stall;
  logic            edge_tick;
  logic            rise;
  logic            fall;
  logic            buf_full;
  logic            buf_valid;
  logic [7:0]      buf_data;
  logic            buf_pop;
  logic            tdi_s1_q;
  logic            tdi_s2_q;
  logic            tdi_s3_q;
  logic            tdi_lvl_q;

  // Software reset acts on the cycle after the write
  assign rst_all = rst_i | soft_rst_q;

  // Wishbone slave
  assign req      = wb_cyc_i & wb_stb_i;
  assign hit_cmd  = (wb_adr_i[7:2] == TMS_ADDR_CMD[7:2]);
  assign hit_out  = (wb_adr_i[7:2] == TMS_ADDR_OUTBUF[7:2]);
  assign wr_fire  = ce_i & ack_q & req & wb_we_i;
  assign cmd      = tms_cmd_t'(wb_dat_i[7:0]);
  assign start    = wr_fire & hit_cmd & wb_sel_i[0] & ~cmd.soft_reset_bit
                    & ~cfg_q.discrete & ~busy_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_comb begin
    rdat = 32'h0000_0000;
    unique case (wb_adr_i[7:2])
      TMS_ADDR_STATUS[7:2]: begin
        rdat[TMS_STAT_FULL_BIT] = buf_full;
        rdat[TMS_STAT_BUSY_BIT] = busy_q;
        rdat[3:0]               = tap_q;
      end
      TMS_ADDR_LEN[7:2]:  rdat[15:0] = len_q;
      TMS_ADDR_DISC[7:2]: rdat[7:0]  = disc_q;
      TMS_ADDR_CFG[7:2]:  rdat[7:0]  = cfg_q;
      default:            rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (ack_q) begin
        ack_q <= 1'b0;
      end else if (req && !(wb_we_i && hit_out && buf_full)) begin
        ack_q  <= 1'b1;
        rdat_q <= wb_we_i ? 32'h0000_0000 : rdat;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
    end else if (ce_i) begin
      soft_rst_q <= ~soft_rst_q & wr_fire & hit_cmd & wb_sel_i[0]
                    & cmd.soft_reset_bit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      cfg_q  <= tms_cfg_t'(TMS_CFG_RESET);
      disc_q <= tms_disc_t'(TMS_DISC_RESET);
      len_q  <= TMS_LEN_RESET;
    end else if (wr_fire) begin
      if (wb_adr_i[7:2] == TMS_ADDR_CFG[7:2] && wb_sel_i[0]) begin
        cfg_q <= tms_cfg_t'({5'h00, wb_dat_i[2:0]});
      end
      if (wb_adr_i[7:2] == TMS_ADDR_DISC[7:2] && wb_sel_i[0]) begin
        disc_q <= tms_disc_t'({6'h00, wb_dat_i[1:0]});
      end
      if (wb_adr_i[7:2] == TMS_ADDR_LEN[7:2]) begin
        if (wb_sel_i[0]) begin
          len_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          len_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  tms_out_fifo #(
    .WIDTH (TMS_BUF_WIDTH),
    .DEPTH (TMS_BUF_DEPTH)
  ) u_out_fifo (
    .clk_i        (clk_i),
    .rst_i        (rst_all),
    .ce_i         (ce_i),
    .clear_i      (start),
    .push_valid_i (wr_fire & hit_out & wb_sel_i[0]),
    .push_ready_o (),
    .push_data_i  (wb_dat_i[7:0]),
    .pop_valid_o  (buf_valid),
    .pop_ready_i  (buf_pop),
    .pop_data_o   (buf_data),
    .full_o       (buf_full)
  );

  // Test clock; a buffered scan waits with TCK high for the next byte
  assign in_shift  = scan_q & (tap_q == target_q);
  assign stall     = tck_q & in_shift & (mode_q == MODE_BUFFER) & ~buf_valid;
  assign edge_tick = ce_i & (cnt_q == CW'(HALF - 1)) & ~stall;
  assign rise      = edge_tick & ~tck_q;
  assign fall      = edge_tick & tck_q;
  assign buf_pop   = rise & in_shift & (mode_q == MODE_BUFFER)
                     & ((bit_q == 3'h7) || (rem_q == 16'h0001));

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      cnt_q <= '0;
      tck_q <= 1'b0;
    end else if (ce_i && !stall) begin
      if (cnt_q == CW'(HALF - 1)) begin
        cnt_q <= '0;
        tck_q <= ~tck_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  // Target state record and command progress on each TCK rise
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tap_q    <= TAP_RESET;
      busy_q   <= 1'b0;
      scan_q   <= 1'b0;
      mode_q   <= MODE_MOVE;
      goal_q   <= TAP_RESET;
      target_q <= TAP_RESET;
      rem_q    <= 16'h0000;
      bit_q    <= 3'h0;
    end else if (start) begin
      busy_q   <= 1'b1;
      mode_q   <= cmd.mode;
      goal_q   <= goal_state(cmd.goal);
      bit_q    <= 3'h0;
      rem_q    <= len_q;
      scan_q   <= (cmd.mode != MODE_MOVE) && (len_q != 16'h0000);
      if (cmd.mode != MODE_MOVE && len_q != 16'h0000) begin
        target_q <= cmd.ir_path ? TAP_SHIFT_IR : TAP_SHIFT_DR;
      end else begin
        target_q <= goal_state(cmd.goal);
      end
    end else if (rise) begin
      tap_q <= tap_next(tap_q, tms_q);
      if (in_shift) begin
        rem_q <= rem_q - 16'h0001;
        bit_q <= buf_pop ? 3'h0 : bit_q + 3'h1;
        if (rem_q == 16'h0001) begin
          scan_q   <= 1'b0;
          target_q <= goal_q;
        end
      end else if (busy_q && !scan_q && tap_next(tap_q, tms_q) == goal_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  // TMS and scan data change on the TCK fall
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tms_q <= 1'b1;
      tdo_q <= 1'b1;
    end else if (fall) begin
      if (in_shift && rem_q > 16'h0001) begin
        tms_q <= 1'b0;
      end else begin
        tms_q <= tms_toward(tap_q, in_shift ? goal_q : target_q);
      end
      if (in_shift) begin
        unique case (mode_q)
          MODE_BUFFER:  tdo_q <= buf_data[bit_q];
          MODE_RECIRC:  tdo_q <= tdi_lvl_q;
          MODE_IN_ONLY: tdo_q <= 1'b1;
          MODE_MOVE:    tdo_q <= 1'b1;
        endcase
      end else begin
        tdo_q <= 1'b1;
      end
    end
  end

  // Serial input from the target, filtered over the last two stages
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tdi_s1_q  <= 1'b1;
      tdi_s2_q  <= 1'b1;
      tdi_s3_q  <= 1'b1;
      tdi_lvl_q <= 1'b1;
    end else if (ce_i) begin
      tdi_s1_q <= tdi_i;
      tdi_s2_q <= tdi_s1_q;
      tdi_s3_q <= tdi_s2_q;
      if (tdi_s2_q == tdi_s3_q) begin
        tdi_lvl_q <= tdi_s3_q;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tck_o        <= 1'b0;
      tms_o        <= 1'b1;
      tdo_o        <= 1'b1;
      trst_n_o     <= 1'b1;
      loop_bit_o   <= 1'b0;
      loop_valid_o <= 1'b0;
    end else if (ce_i) begin
      tck_o    <= tck_q;
      trst_n_o <= ~cfg_q.trst_assert;
      if (cfg_q.loopback) begin
        tms_o <= 1'b1;
        tdo_o <= 1'b1;
      end else if (cfg_q.discrete) begin
        tms_o <= disc_q.tms_level;
        tdo_o <= disc_q.tdo_level;
      end else begin
        tms_o <= tms_q;
        tdo_o <= tdo_q;
      end
      loop_valid_o <= rise & in_shift & cfg_q.loopback;
      loop_bit_o   <= tdo_q;
    end
  end
endmodule

// ### verification/tms_tap_master_asserts.sv
/*
  Checker of the TAP master ports: bus answers, pin levels after reset,
  test clock low phase, TMS timing and register read values.
  Assumes binding to tms_tap_master and a classic Wishbone master.
*/
`timescale 1ns/1ps
module tms_tap_master_asserts
  import tms_pkg::*;
#(
  parameter int TCK_DIV = TMS_TCK_DIV_RESET
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tdi_i,
  input wire logic        tck_o,
  input wire logic        tms_o,
  input wire logic        tdo_o,
  input wire logic        trst_n_o,
  input wire logic        loop_bit_o,
  input wire logic        loop_valid_o
);
  logic       tck_q;
  logic       seen_q;
  logic       fix_q;
  logic [7:0] cnt_q;
  logic [2:0] calm_q;
  logic       wr_ack;
  logic       cfg_wr;
  assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign cfg_wr = wr_ack && wb_adr_i[7:2] == TMS_ADDR_CFG[7:2];
  // Length of each test clock phase
  always_ff @(posedge clk_i) begin
    tck_q  <= rst_i ? 1'b0 : tck_o;
    seen_q <= rst_i ? 1'b0 : (seen_q || (tck_o && !tck_q));
    cnt_q  <= (rst_i || tck_o != tck_q) ? 8'h01 : cnt_q + 8'h01;
  end
  // Pin overrides and soft reset move TMS off the clock
  always_ff @(posedge clk_i) begin
    fix_q  <= rst_i ? 1'b0 : (cfg_wr ? |wb_dat_i[1:0] : fix_q);
    calm_q <= (rst_i || fix_q || cfg_wr || (wr_ack && wb_adr_i[7:2] == TMS_ADDR_CMD[7:2]
               && wb_dat_i[7])) ? 3'h7 : (calm_q == 3'h0 ? 3'h0 : calm_q - 3'h1);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_new;
    $rose(wb_stb_i) && wb_adr_i[7:2] != TMS_ADDR_OUTBUF[7:2];
  endsequence
  sequence s_rd(logic [5:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == a;
  endsequence
  a_reset_pins_high: assert property ($past(rst_i) |-> tms_o && tdo_o && trst_n_o
    && !tck_o && !wb_ack_o) else $error("pins not at reset levels after reset");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (s_req_new |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_tck_low_phase: assert property (seen_q && calm_q == 3'h0 && tck_o && !tck_q |->
    cnt_q == TCK_DIV / 2) else $error("test clock low phase of wrong length");
  a_tms_on_low: assert property ($changed(tms_o) && calm_q == 3'h0 |-> !tck_o)
    else $error("TMS changed while test clock high");
  a_loop_pins_high: assert property (loop_valid_o |-> tms_o && tdo_o)
    else $error("pins not high during loopback");
  a_cmd_reads_zero: assert property (s_rd(TMS_ADDR_CMD[7:2]) |-> wb_dat_o == 32'h0)
    else $error("command register read not zero");
  a_status_spare: assert property (s_rd(TMS_ADDR_STATUS[7:2]) |->
    wb_dat_o[31:7] == 25'h0 && !wb_dat_o[4]) else $error("status spare bits set");
endmodule

bind tms_tap_master tms_tap_master_asserts #(.TCK_DIV(TCK_DIV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tdi_i(tdi_i), .tck_o(tck_o), .tms_o(tms_o),
  .tdo_o(tdo_o), .trst_n_o(trst_n_o), .loop_bit_o(loop_bit_o), .loop_valid_o(loop_valid_o));

// ### verification/tms_target_model.sv
/*
  Behavioural scan target: TAP state machine, capture and shift register.
  Assumes the master drives TCK, TMS, its data line and test reset.
*/
`timescale 1ns/1ps
module tms_target_model
  import tms_pkg::*;
(
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdo_i,
  input  wire logic        trst_n_i,
  output logic             tdi_o,
  output tms_tap_t         state_o,
  output logic [31:0]      rx_o,
  output logic [7:0]       rxn_o
);
  logic [31:0] sreg_q;
  logic [31:0] upd_q;
  logic [3:0]  ir_q;
  logic        shift;
  assign shift = state_o == TAP_SHIFT_DR || state_o == TAP_SHIFT_IR;
  function automatic tms_tap_t nxt(input tms_tap_t s, input logic m);
    case (s)
      TAP_RESET:    return m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_SEL_IR:   return m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return m ? TAP_UPD_IR : TAP_SHIFT_IR;
      default:      return m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction
  initial begin
    state_o = TAP_RESET;
    tdi_o = 1'b0;
    rx_o = 32'h0;
    rxn_o = 8'h00;
    ir_q = 4'h1;
    sreg_q = 32'h0;
  end
  always @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_o <= TAP_RESET;
    end else begin
      if (state_o == TAP_CAP_DR || state_o == TAP_CAP_IR) begin
        sreg_q <= (state_o == TAP_CAP_IR) ? {28'h0, ir_q} : 32'hC3A50F96;
        rx_o <= 32'h0;
        rxn_o <= 8'h00;
      end
      if (shift) begin
        sreg_q <= {tdo_i, sreg_q[31:1]};
        rx_o <= {tdo_i, rx_o[31:1]};
        rxn_o <= rxn_o + 8'h01;
      end
      state_o <= nxt(state_o, tms_i);
    end
  end
  // Released line never repeats its last level
  always @(negedge tck_i) begin
    tdi_o <= shift ? sreg_q[0] : ~tdi_o;
    if (state_o == TAP_UPD_DR) upd_q <= sreg_q;
    if (state_o == TAP_UPD_IR) ir_q <= sreg_q[3:0];
    if (state_o == TAP_RESET) ir_q <= 4'h1;
  end
endmodule

// ### verification/tb_tms_tap_master.sv
/*
  Bench of the TAP master: state moves, buffered and input-only scans,
  loopback, buffer stall, soft reset and discrete pins.
  Assumes the target model on the pins and the bound checker.
*/
`timescale 1ns/1ps
module tb_tms_tap_master;
  import tms_pkg::*;
  localparam logic [7:0] GOAL [8] = '{8'h18, 8'h19, 8'h1B, 8'h1D, 8'h18, 8'h19, 8'h1D, 8'h1B};
  localparam int         LENS [8] = '{5, 3, 2, 7, 5, 3, 2, 6};
  localparam logic [7:0] SEQS [8] = '{8'h1F, 8'h06, 8'h02, 8'h7A, 8'h1F, 8'h06, 8'h02, 8'h3A};
  localparam tms_tap_t   ENDS [8] = '{TAP_RESET, TAP_IDLE, TAP_PAUSE_DR, TAP_PAUSE_IR,
                                      TAP_RESET, TAP_IDLE, TAP_PAUSE_IR, TAP_PAUSE_DR};
  logic        clk_i, rst_i, cyc, stb, we, ack, tdi, tck, tms, tdo, trst_n, lbit, lval, g;
  logic [7:0]  adr, rxn, lbits, lcnt;
  logic [31:0] wdat, rdat, rv, rx;
  tms_tap_t    st;
  logic        tq[$];
  int          errors, cmp_count;
  tms_tap_master #(.TCK_DIV(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tdi_i(tdi), .tck_o(tck), .tms_o(tms), .tdo_o(tdo),
    .trst_n_o(trst_n), .loop_bit_o(lbit), .loop_valid_o(lval));
  tms_target_model u_tgt (.tck_i(tck), .tms_i(tms), .tdo_i(tdo), .trst_n_i(trst_n),
    .tdi_o(tdi), .state_o(st), .rx_o(rx), .rxn_o(rxn));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge tck) tq.push_back(tms);
  always @(negedge clk_i) begin
    if (lval === 1'b1) begin
      lbits = {lbit, lbits[7:1]};
      lcnt++;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input int lim);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < lim);
    g = ack === 1'b1;
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 200);
    if (g !== 1'b1) chk({31'h0, g}, 32'h1);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, TMS_ADDR_STATUS, 32'h0, 200);
      n++;
    end while (rv[TMS_STAT_BUSY_BIT] !== 1'b0 && n < 400);
    chk({31'h0, rv[TMS_STAT_BUSY_BIT]}, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 200);
    chk(rv & m, e);
  endtask
  task automatic move(input logic [7:0] c, input int len, input logic [7:0] b, input tms_tap_t e);
    int i;
    logic [7:0] v;
    i = 0;
    v = 8'h00;
    wr(TMS_ADDR_CMD, {24'h0, c});
    tq.delete();
    idle();
    while (i < tq.size() && tq[i] === 1'b0) i++;
    for (int k = 0; k < len; k++) v = {v[6:0], (i + k < tq.size()) ? tq[i + k] : 1'bx};
    chk({24'h0, v}, {24'h0, b});
    chk({28'h0, st}, {28'h0, e});
    rdc(TMS_ADDR_STATUS, 32'hF, {28'h0, e});
  endtask
  task automatic t_reset();
    rdc(TMS_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    rdc(TMS_ADDR_DISC, 32'hFFFFFFFF, {24'h0, TMS_DISC_RESET});
    rdc(TMS_ADDR_CMD, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, tms & tdo & trst_n}, 32'h1);
    $display("done: reset values");
  endtask
  task automatic t_moves();
    for (int p = 0; p < 8; p++) begin
      move(p < 4 ? 8'h1A : 8'h1C, 0, 8'h00, p < 4 ? TAP_SHIFT_DR : TAP_SHIFT_IR);
      move(GOAL[p], LENS[p], SEQS[p], ENDS[p]);
    end
    $display("done: moves from shift states");
  endtask
  task automatic t_scan();
    move(8'h19, 0, 8'h00, TAP_IDLE);
    wr(TMS_ADDR_LEN, 32'h0000000C);
    wr(TMS_ADDR_OUTBUF, 32'h000000FF);
    wr(TMS_ADDR_CMD, 32'h00000001);
    wr(TMS_ADDR_OUTBUF, 32'h000000A5);
    wr(TMS_ADDR_OUTBUF, 32'h00000003);
    idle();
    chk({24'h0, rxn}, 32'h0000000C);
    chk(rx >> 20, 32'h000003A5);
    wr(TMS_ADDR_LEN, 32'h00000008);
    wr(TMS_ADDR_CMD, 32'h00000009);
    idle();
    chk(rx >> 24, 32'h000000FF);
    $display("done: buffered and input-only scans");
  endtask
  task automatic t_loop();
    lcnt = 8'h00;
    wr(TMS_ADDR_CFG, 32'h00000002);
    wr(TMS_ADDR_CMD, 32'h00000001);
    wr(TMS_ADDR_OUTBUF, 32'h0000005A);
    idle();
    chk({lcnt, lbits}, 32'h0000085A);
    chk({28'h0, st}, {28'h0, TAP_RESET});
    wr(TMS_ADDR_CFG, 32'h00000000);
    $display("done: loopback");
  endtask
  task automatic t_full();
    wr(TMS_ADDR_CMD, 32'h00000019);
    for (int k = 1; k <= 4; k++) wr(TMS_ADDR_OUTBUF, 32'h00000011 * k);
    rdc(TMS_ADDR_STATUS, 32'h00000040, 32'h00000040);
    bus(1'b1, TMS_ADDR_OUTBUF, 32'h00000055, 30);
    chk({31'h0, g}, 32'h0);
    wr(TMS_ADDR_CMD, 32'h00000080);
    repeat (3) @(posedge clk_i);
    rdc(TMS_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    $display("done: buffer stall and soft reset");
  endtask
  task automatic t_disc();
    wr(TMS_ADDR_CFG, 32'h00000005);
    for (int k = 3; k >= 1; k--) begin
      wr(TMS_ADDR_DISC, k);
      repeat (4) @(negedge clk_i);
      chk({29'h0, trst_n, tms, tdo}, k);
    end
    $display("done: discrete pins");
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, lbits, lcnt} = '0;
    errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_moves();
    t_scan();
    t_loop();
    t_full();
    t_disc();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule
